//--- rcr_map.svh
`ifndef RCR_MAP_SVH
`define RCR_MAP_SVH
// register byte addresses
`define RCR_ADDR_CTRL    8'h00
`define RCR_ADDR_COND    8'h04
`define RCR_ADDR_STATUS  8'h08
`define RCR_ADDR_IRQ_ST  8'h0C
`define RCR_ADDR_IRQ_MSK 8'h10
`define RCR_ADDR_WIDTH   8
// control register fields
`define RCR_CTRL_RUN        0
`define RCR_CTRL_SWAP       1
`define RCR_CTRL_FW_PERMIT  2
`define RCR_CTRL_LOG_PERMIT 3
`define RCR_CTRL_ONLINE_MOD 4
`define RCR_CTRL_MAINT      5
`define RCR_CTRL_SAFETY     6
`define RCR_CTRL_WARM       7
`define RCR_CTRL_RESET      8'h00
// condition register fields
`define RCR_COND_FW_DIFF    0
`define RCR_COND_LOG_DIFF   1
`define RCR_COND_SAFE_DIFF  2
`define RCR_COND_ONLINE_CHG 3
`define RCR_COND_HALTED     4
`define RCR_COND_RESET      8'h00
// interrupt events
`define RCR_IRQ_ROLE_CHG 0
`define RCR_IRQ_TO_STOP  1
`define RCR_IRQ_LINK_TO  2
`define RCR_IRQ_W        3
// timing and axi response codes
`define RCR_CLK_HZ       20000000
`define RCR_LINK_TO_S    3
`define RCR_WAIT_CYC     1
`define RCR_AXI_OKAY     2'h0
`define RCR_AXI_SLVERR   2'h2
`endif

//--- rcr_pkg.sv
package rcr_pkg;
	typedef enum logic [1:0] {
		RCR_STOP,
		RCR_WAIT,
		RCR_PRIMARY,
		RCR_STANDBY
	} rcr_role_t;
	typedef enum logic [1:0] {
		RCR_SEL_CLEAR,
		RCR_SEL_A,
		RCR_SEL_B,
		RCR_SEL_BAD
	} rcr_sel_t;
endpackage

//--- rcr_cfg_if.sv
`timescale 1ns/1ns
interface rcr_cfg_if;
	logic [7:0] ctrl;
	logic [7:0] cond;
	logic       swap_pulse;
	logic [3:0] events;
	logic [1:0] role;
	logic       link_to;
	modport regs (output ctrl, output cond, output swap_pulse, input events, input role,
		input link_to);
	modport core (input ctrl, input cond, input swap_pulse, output events, output role,
		output link_to);
endinterface

//--- rcr_axil_regs.sv
`timescale 1ns/1ns
`include "rcr_map.svh"
module rcr_axil_regs
	import rcr_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// core side
	rcr_cfg_if.regs          cfg,
	output logic             irq
);
	typedef struct packed {
		logic                 awrdy;
		logic                 wrdy;
		logic                 arrdy;
		logic                 aw_got;
		logic [7:0]           awaddr;
		logic                 w_got;
		logic [7:0]           wdata;
		logic                 wstrb0;
		logic                 bvalid;
		logic [1:0]           bresp;
		logic                 rvalid;
		logic [31:0]          rdata;
		logic [1:0]           rresp;
		logic [7:0]           ctrl;
		logic [7:0]           cond;
		logic                 swap;
		logic [`RCR_IRQ_W-1:0] ist;
		logic [`RCR_IRQ_W-1:0] imsk;
		logic                 irq;
	} rcr_regs_t;
	rcr_regs_t s_q, s_d;
	logic        wr_fire;
	logic [7:0]  wv;

	assign wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
	assign wv      = s_q.wstrb0 ? s_q.wdata : 8'h00;

	always_comb begin
		s_d = s_q;
		s_d.swap = 1'b0;
		// registered readies: raised one cycle after valid, dropped at the handshake
		s_d.awrdy = s_axi_awvalid && !s_q.awrdy && !s_q.aw_got;
		s_d.wrdy  = s_axi_wvalid && !s_q.wrdy && !s_q.w_got;
		s_d.arrdy = s_axi_arvalid && !s_q.arrdy && !s_q.rvalid;
		if (s_axi_awvalid && s_q.awrdy) begin
			s_d.aw_got = 1'b1;
			s_d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_q.wrdy) begin
			s_d.w_got  = 1'b1;
			s_d.wdata  = s_axi_wdata[7:0];
			s_d.wstrb0 = s_axi_wstrb[0];
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end
		// sticky events: set wins over a write-one clear in the same cycle
		s_d.ist = s_q.ist | cfg.events[`RCR_IRQ_W-1:0];
		if (wr_fire) begin
			s_d.aw_got = 1'b0;
			s_d.w_got  = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp  = `RCR_AXI_OKAY;
			unique case (s_q.awaddr)
				`RCR_ADDR_CTRL: begin
					if (s_q.wstrb0) begin
						s_d.ctrl = wv;
						s_d.ctrl[`RCR_CTRL_SWAP] = 1'b0;
						s_d.swap = wv[`RCR_CTRL_SWAP];
					end
				end
				`RCR_ADDR_COND: begin
					if (s_q.wstrb0) begin
						s_d.cond = wv;
					end
				end
				`RCR_ADDR_STATUS: begin
				end
				`RCR_ADDR_IRQ_ST: begin
					s_d.ist = (s_q.ist & ~wv[`RCR_IRQ_W-1:0]) | cfg.events[`RCR_IRQ_W-1:0];
				end
				`RCR_ADDR_IRQ_MSK: begin
					if (s_q.wstrb0) begin
						s_d.imsk = wv[`RCR_IRQ_W-1:0];
					end
				end
				default: begin
					s_d.bresp = `RCR_AXI_SLVERR;
				end
			endcase
		end
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_q.arrdy) begin
			s_d.rvalid = 1'b1;
			s_d.rdata  = 32'h0000_0000;
			s_d.rresp  = `RCR_AXI_OKAY;
			unique case (s_axi_araddr)
				`RCR_ADDR_CTRL:    s_d.rdata[7:0] = s_q.ctrl;
				`RCR_ADDR_COND:    s_d.rdata[7:0] = s_q.cond;
				`RCR_ADDR_STATUS:  s_d.rdata[2:0] = {cfg.link_to, cfg.role};
				`RCR_ADDR_IRQ_ST:  s_d.rdata[`RCR_IRQ_W-1:0] = s_q.ist;
				`RCR_ADDR_IRQ_MSK: s_d.rdata[`RCR_IRQ_W-1:0] = s_q.imsk;
				default:           s_d.rresp = `RCR_AXI_SLVERR;
			endcase
		end
		s_d.irq = |(s_d.ist & s_d.imsk);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
			s_q.ctrl <= `RCR_CTRL_RESET;
			s_q.cond <= `RCR_COND_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign s_axi_awready  = s_q.awrdy;
	assign s_axi_wready   = s_q.wrdy;
	assign s_axi_arready  = s_q.arrdy;
	assign s_axi_bvalid   = s_q.bvalid;
	assign s_axi_bresp    = s_q.bresp;
	assign s_axi_rvalid   = s_q.rvalid;
	assign s_axi_rdata    = s_q.rdata;
	assign s_axi_rresp    = s_q.rresp;
	assign cfg.ctrl       = s_q.ctrl;
	assign cfg.cond       = s_q.cond;
	assign cfg.swap_pulse = s_q.swap;
	assign irq            = s_q.irq;
endmodule

//--- rcr_role_fsm.sv
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "rcr_map.svh"
// Function
// - primary lost all adapters, peer reaches some: standby
// - halted primary hands over to healthy standby peer
// - swap command with standby peer: leave primary
// - primary-to-standby needs all mismatch permissions
// - run-to-stop forces the stop role
// - primary-to-standby passes wait at least one cycle
// - A/B selector gives identity, breaks ties
// - firmware mismatch tolerated only with its permit
// - logic mismatch needs permit and online modification
// - safety mismatch also needs maintenance mode
// - sequential start: first primary, second standby
// - simultaneous start: A primary, B standby
// - healthy links: roles held, no spontaneous change
// - standby link silent over 3 s: standby to wait
// - both links to peer lost: standby becomes primary
// - standby link dead, later starter enters wait
module rcr_role_fsm
	import rcr_pkg::*;
#(
	parameter int unsigned LINK_TO_CYC = `RCR_LINK_TO_S * `RCR_CLK_HZ
)(
	// clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// axi4-lite register slave
	input  wire logic [7:0]       s_axi_awaddr,
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	output logic [1:0]            s_axi_bresp,
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	input  wire logic [7:0]       s_axi_araddr,
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	output logic [31:0]           s_axi_rdata,
	output logic [1:0]            s_axi_rresp,
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready,
	// identity selector
	input  wire rcr_pkg::rcr_sel_t id_sel,
	// link health
	input  wire logic             standby_link_ok,
	input  wire logic             remote_io_ring_ok,
	input  wire logic             adapter_reach,
	// counterpart status received over the standby link
	input  wire rcr_pkg::rcr_role_t peer_role,
	input  wire logic             peer_adapter_reach,
	input  wire logic             peer_all_run,
	input  wire logic             peer_swap_req,
	// results
	output rcr_pkg::rcr_role_t    role,
	output logic                  irq
);
	import rcr_pkg::*;

	typedef struct packed {
		rcr_role_t   role;
		logic        run;
		logic [31:0] silent;
		logic        link_to;
		logic        wait_done;
		logic        from_primary;
		logic [3:0]  events;
	} rcr_core_t;
	rcr_core_t s_q, s_d;

	rcr_cfg_if cfg ();

	rcr_axil_regs u_regs (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.cfg           (cfg.regs),
		.irq           (irq)
	);

	////////////////////////////////////////////////////////////////////////////////
	logic run_cmd, warm, halted, swap_cmd;
	logic firmware_diff_permit, fw_ok, log_ok, safe_ok, precond_ok;
	logic is_a, is_b, peer_silent, to_standby;

	assign run_cmd              = cfg.ctrl[`RCR_CTRL_RUN];
	assign warm                 = cfg.ctrl[`RCR_CTRL_WARM];
	assign halted               = cfg.cond[`RCR_COND_HALTED];
	assign swap_cmd             = cfg.swap_pulse || peer_swap_req;
	assign firmware_diff_permit = cfg.ctrl[`RCR_CTRL_FW_PERMIT];
	assign is_a                 = (id_sel == RCR_SEL_A);
	assign is_b                 = (id_sel == RCR_SEL_B);

	assign fw_ok = !cfg.cond[`RCR_COND_FW_DIFF] || firmware_diff_permit;
	assign log_ok = !(cfg.cond[`RCR_COND_LOG_DIFF] || cfg.cond[`RCR_COND_ONLINE_CHG])
		|| (cfg.ctrl[`RCR_CTRL_LOG_PERMIT] && cfg.ctrl[`RCR_CTRL_ONLINE_MOD]);
	// safe-part mismatch only matters on safety controllers
	assign safe_ok = !(cfg.ctrl[`RCR_CTRL_SAFETY] && cfg.cond[`RCR_COND_SAFE_DIFF])
		|| (log_ok && cfg.ctrl[`RCR_CTRL_LOG_PERMIT] && cfg.ctrl[`RCR_CTRL_MAINT]);
	assign precond_ok = fw_ok && log_ok && safe_ok;

	// silent: peer unreachable on both paths
	assign peer_silent = !standby_link_ok && !remote_io_ring_ok;

	// hand-over triggers out of primary; all need a standby peer and a live link
	assign to_standby = standby_link_ok && (peer_role == RCR_STANDBY) && precond_ok && (
		(!adapter_reach && peer_adapter_reach) ||
		(halted && peer_all_run) ||
		cfg.swap_pulse);

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_d        = s_q;
		s_d.run    = run_cmd;
		s_d.events = 4'h0;
		// silence counter saturates so a long outage cannot wrap
		if (standby_link_ok) begin
			s_d.silent  = 32'h0000_0000;
			s_d.link_to = 1'b0;
		end else if (s_q.silent < LINK_TO_CYC) begin
			s_d.silent = s_q.silent + 32'h0000_0001;
		end else begin
			s_d.link_to = 1'b1;
		end
		if (s_d.link_to && !s_q.link_to) begin
			s_d.events[`RCR_IRQ_LINK_TO] = 1'b1;
		end
		if (s_q.run && !run_cmd) begin
			s_d.role = RCR_STOP;
			s_d.events[`RCR_IRQ_TO_STOP] = 1'b1;
		end else begin
			unique case (s_q.role)
				RCR_STOP: begin
					if (run_cmd) begin
						s_d.role = RCR_WAIT;
						s_d.from_primary = 1'b0;
					end
				end
				RCR_WAIT: begin
					s_d.wait_done = 1'b1;
					if (!run_cmd) begin
						s_d.role = RCR_WAIT;
					end else if (s_q.from_primary && !s_q.wait_done) begin
						s_d.role = RCR_WAIT;
					end else if (standby_link_ok && peer_role == RCR_PRIMARY && precond_ok) begin
						s_d.role = RCR_STANDBY;
					end else if (standby_link_ok && peer_role == RCR_PRIMARY) begin
						s_d.role = RCR_WAIT;
					end else if (!standby_link_ok && remote_io_ring_ok && s_q.silent == 32'h0) begin
						s_d.role = RCR_WAIT;
					end else if (!standby_link_ok && remote_io_ring_ok && !s_q.from_primary
						&& !s_q.link_to) begin
						s_d.role = RCR_WAIT;
					end else if (!s_q.from_primary && (is_a || peer_role != RCR_WAIT
						|| !standby_link_ok)) begin
						s_d.role = RCR_PRIMARY;
					end else if (warm && !s_q.from_primary) begin
						s_d.role = RCR_PRIMARY;
					end
				end
				RCR_PRIMARY: begin
					if (to_standby) begin
						s_d.role = RCR_WAIT;
						s_d.from_primary = 1'b1;
						s_d.wait_done = 1'b0;
					end else if (is_b && standby_link_ok && peer_role == RCR_PRIMARY) begin
						s_d.role = RCR_WAIT;
						s_d.from_primary = 1'b1;
						s_d.wait_done = 1'b0;
					end
				end
				RCR_STANDBY: begin
					if (peer_silent) begin
						s_d.role = RCR_PRIMARY;
					end else if (s_q.link_to && remote_io_ring_ok) begin
						s_d.role = RCR_WAIT;
						// peer still runs as primary: no self-promotion while the link is down
						s_d.from_primary = 1'b1;
					end else if (standby_link_ok && (peer_role == RCR_WAIT
						|| peer_role == RCR_STANDBY || swap_cmd)) begin
						s_d.role = RCR_PRIMARY;
					end
					// otherwise hold with healthy links
				end
			endcase
		end
		if (s_d.role != s_q.role) begin
			s_d.events[`RCR_IRQ_ROLE_CHG] = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
			s_q.role <= RCR_STOP;
		end else begin
			s_q <= s_d;
		end
	end

	assign role        = s_q.role;
	assign cfg.role    = s_q.role;
	assign cfg.link_to = s_q.link_to;
	assign cfg.events  = s_q.events;
endmodule

//--- rcr_role_fsm_checker.sv
`timescale 1ns/1ns
`include "rcr_map.svh"
module rcr_role_fsm_checker
	import rcr_pkg::*;
#(
	parameter int unsigned LINK_TO_CYC = 20
)(
	// clock and reset
	input wire logic              aclk,
	input wire logic              aresetn,
	// register writes
	input wire logic [7:0]        s_axi_awaddr,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic [31:0]       s_axi_wdata,
	input wire logic [3:0]        s_axi_wstrb,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	// role inputs and outputs
	input wire rcr_pkg::rcr_sel_t  id_sel,
	input wire logic              standby_link_ok,
	input wire logic              remote_io_ring_ok,
	input wire rcr_pkg::rcr_role_t peer_role,
	input wire logic              peer_swap_req,
	input wire rcr_pkg::rcr_role_t role,
	input wire logic              irq
);
	logic [31:0] silent_q;
	logic        run_q;
	// cycles the standby link has been silent, saturating
	always_ff @(posedge aclk) begin
		if (!aresetn || standby_link_ok)
			silent_q <= '0;
		else if (silent_q < LINK_TO_CYC)
			silent_q <= silent_q + 32'h1;
	end
	// shadow of the run bit; assumes address and data are taken together
	always_ff @(posedge aclk) begin
		if (!aresetn)
			run_q <= 1'b0;
		else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			&& s_axi_awaddr == `RCR_ADDR_CTRL && s_axi_wstrb[0])
			run_q <= s_axi_wdata[`RCR_CTRL_RUN];
	end
	////////////////////
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_reset_stop; disable iff (1'b0) !aresetn |=> role == RCR_STOP; endproperty
	a_reset_stop: assert property (p_reset_stop) else $error("role not stop");
	property p_wait_pass; $past(role) == RCR_PRIMARY |-> role != RCR_STANDBY; endproperty
	a_wait_pass: assert property (p_wait_pass) else $error("wait skipped");
	property p_wait_hold;
		$past(role) == RCR_PRIMARY && role == RCR_WAIT |=> role inside {RCR_WAIT, RCR_STOP};
	endproperty
	a_wait_hold: assert property (p_wait_hold) else $error("wait too short");
	property p_stop_prio; $fell(run_q) |-> ##[0:2] role == RCR_STOP; endproperty
	a_stop_prio: assert property (p_stop_prio) else $error("no stop");
	property p_silent;
		role == RCR_WAIT && $past(role) == RCR_STANDBY |-> silent_q >= LINK_TO_CYC - 2;
	endproperty
	a_silent: assert property (p_silent) else $error("early wait");
	property p_lost_both;
		role == RCR_STANDBY && !standby_link_ok && !remote_io_ring_ok
			|-> ##[1:40] role inside {RCR_PRIMARY, RCR_STOP};
	endproperty
	a_lost_both: assert property (p_lost_both) else $error("no takeover");
	property p_hold;
		role == RCR_STANDBY && standby_link_ok && remote_io_ring_ok
			&& peer_role == RCR_PRIMARY && !peer_swap_req |=> role inside {RCR_STANDBY, RCR_STOP};
	endproperty
	a_hold: assert property (p_hold) else $error("standby lost");
	property p_tie_b;
		role == RCR_WAIT && id_sel == RCR_SEL_B && peer_role == RCR_WAIT && standby_link_ok
			|=> role != RCR_PRIMARY;
	endproperty
	a_tie_b: assert property (p_tie_b) else $error("b took primary");
	c_swap: cover property (role == RCR_STANDBY ##1 role == RCR_PRIMARY);
	c_wait: cover property (role == RCR_PRIMARY ##1 role == RCR_WAIT);
	c_irq: cover property ($rose(irq));
endmodule
bind rcr_role_fsm rcr_role_fsm_checker #(.LINK_TO_CYC(LINK_TO_CYC)) u_chk (.aclk, .aresetn,
	.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
	.s_axi_wvalid, .s_axi_wready, .id_sel, .standby_link_ok, .remote_io_ring_ok,
	.peer_role, .peer_swap_req, .role, .irq);

//--- rcr_peer_model.sv
`timescale 1ns/1ns
module rcr_peer_model
	import rcr_pkg::*;
(
	// clock and reset
	input wire logic              aclk,
	input wire logic              aresetn,
	// bench controls
	input wire logic              run,
	input wire logic              is_a,
	input wire logic              swap_cmd,
	input wire logic              link_ok,
	// link to the device
	input wire rcr_pkg::rcr_role_t dut_role,
	output rcr_pkg::rcr_role_t     peer_role,
	output logic                   peer_swap_req
);
	always_ff @(posedge aclk) begin
		peer_swap_req <= 1'b0;
		if (!aresetn || !run) begin
			peer_role <= RCR_STOP;
		end else begin
			case (peer_role)
				RCR_STOP: peer_role <= RCR_WAIT;
				RCR_WAIT: begin
					if (link_ok && dut_role == RCR_PRIMARY)
						peer_role <= RCR_STANDBY;
					else if (dut_role == RCR_STOP || (dut_role == RCR_WAIT && is_a))
						peer_role <= RCR_PRIMARY;
				end
				RCR_PRIMARY: begin
					// swap only hands over to a live standby, via wait
					if (swap_cmd && dut_role == RCR_STANDBY) begin
						peer_swap_req <= 1'b1;
						peer_role <= RCR_WAIT;
					end
				end
				default: begin
					if (dut_role inside {RCR_WAIT, RCR_STANDBY})
						peer_role <= RCR_PRIMARY;
				end
			endcase
		end
	end
endmodule

//--- rcr_role_fsm_tb_top.sv
`timescale 1ns/1ns
`include "rcr_map.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module rcr_role_fsm_tb_top;
	import rcr_pkg::*;
	logic        aclk = 1'b0, aresetn = 1'b0, irq, peer_swap_req;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	rcr_sel_t    id_sel = RCR_SEL_A;
	logic        standby_link_ok = 1'b1, remote_io_ring_ok = 1'b1, adapter_reach = 1'b1;
	logic        peer_adapter_reach = 1'b1, peer_all_run = 1'b1, prun = 1'b0, swap_cmd = 1'b0;
	rcr_role_t   peer_role, role;
	int          fail_count = 0, compares = 0;
	always #25 aclk = ~aclk;
	// short link timeout keeps the run small
	rcr_role_fsm #(.LINK_TO_CYC(20)) u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .id_sel, .standby_link_ok,
		.remote_io_ring_ok, .adapter_reach, .peer_role, .peer_adapter_reach, .peer_all_run,
		.peer_swap_req, .role, .irq);
	rcr_peer_model u_peer (.aclk, .aresetn, .run(prun), .is_a(id_sel == RCR_SEL_B),
		.swap_cmd, .link_ok(standby_link_ok), .dut_role(role), .peer_role, .peer_swap_req);
	////////////////////
	task automatic results();
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic [1:0] r);
		int i;
		logic ra, rw, rb;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		// readies and answers are settled mid-cycle: sample there, act at the next edge
		for (i = 0; i < 40; i++) begin
			@(negedge aclk);
			ra = s_axi_awready | s_axi_arready;
			rw = s_axi_wready;
			rb = s_axi_bvalid | s_axi_rvalid;
			q = s_axi_rdata;
			r = w ? s_axi_bresp : s_axi_rresp;
			@(posedge aclk);
			if (ra) s_axi_awvalid <= 1'b0;
			if (ra) s_axi_arvalid <= 1'b0;
			if (rw) s_axi_wvalid <= 1'b0;
			if (rb) begin
				s_axi_bready <= 1'b0;
				s_axi_rready <= 1'b0;
				break;
			end
		end
		if (i == 40) begin
			fail_count++;
			results();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic [1:0]  r;
		bus(1'b1, a, d, q, r);
		`CHK(r, `RCR_AXI_OKAY)
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] q;
		logic [1:0]  r;
		bus(1'b0, a, 32'h0, q, r);
		`CHK(q, e)
		`CHK(r, er)
	endtask
	task automatic wait_role(input rcr_role_t e, input int n);
		int i;
		for (i = 0; i < n && role !== e; i++) @(negedge aclk);
		`CHK(role, e)
		if (role !== e) results();
	endtask
	task automatic edge_set(input int n);
		repeat (n) @(negedge aclk);
	endtask
	////////////////////
	task automatic t_regs();
		rd(`RCR_ADDR_STATUS, 32'h0, `RCR_AXI_OKAY);
		rd(`RCR_ADDR_CTRL, 32'h0, `RCR_AXI_OKAY);
		rd(8'h14, 32'h0, `RCR_AXI_SLVERR);
		wr(`RCR_ADDR_IRQ_MSK, 32'h7);
		rd(`RCR_ADDR_IRQ_MSK, 32'h7, `RCR_AXI_OKAY);
		$display("t_regs done");
	endtask
	task automatic t_seq();
		@(posedge aclk);
		prun <= 1'b1;
		repeat (3) @(posedge aclk);
		wr(`RCR_ADDR_CTRL, 32'h1);
		wait_role(RCR_STANDBY, 8);
		edge_set(3);
		`CHK(irq, 1'b1)
		wr(`RCR_ADDR_IRQ_ST, 32'h7);
		edge_set(3);
		`CHK(irq, 1'b0)
		$display("t_seq done");
	endtask
	task automatic t_swap();
		@(posedge aclk);
		swap_cmd <= 1'b1;
		wait_role(RCR_PRIMARY, 8);
		@(posedge aclk);
		swap_cmd <= 1'b0;
		edge_set(4);
		`CHK(peer_role, RCR_STANDBY)
		edge_set(10);
		`CHK(role, RCR_PRIMARY)
		wr(`RCR_ADDR_COND, 32'h10);
		wait_role(RCR_STANDBY, 10);
		wr(`RCR_ADDR_COND, 32'h0);
		@(posedge aclk);
		swap_cmd <= 1'b1;
		wait_role(RCR_PRIMARY, 8);
		@(posedge aclk);
		swap_cmd <= 1'b0;
		$display("t_swap done");
	endtask
	task automatic t_lost();
		// firmware, logic and safe-part mismatch all present
		wr(`RCR_ADDR_COND, 32'h7);
		@(posedge aclk);
		adapter_reach <= 1'b0;
		edge_set(8);
		`CHK(role, RCR_PRIMARY)
		wr(`RCR_ADDR_CTRL, 32'hD);
		edge_set(8);
		`CHK(role, RCR_PRIMARY)
		wr(`RCR_ADDR_CTRL, 32'h5D);
		edge_set(8);
		`CHK(role, RCR_PRIMARY)
		wr(`RCR_ADDR_CTRL, 32'h7D);
		wait_role(RCR_STANDBY, 10);
		@(posedge aclk);
		adapter_reach <= 1'b1;
		wr(`RCR_ADDR_COND, 32'h0);
		$display("t_lost done");
	endtask
	task automatic t_link();
		@(posedge aclk);
		standby_link_ok <= 1'b0;
		edge_set(15);
		`CHK(role, RCR_STANDBY)
		wait_role(RCR_WAIT, 15);
		@(posedge aclk);
		standby_link_ok <= 1'b1;
		wait_role(RCR_STANDBY, 10);
		@(posedge aclk);
		standby_link_ok <= 1'b0;
		remote_io_ring_ok <= 1'b0;
		wait_role(RCR_PRIMARY, 30);
		@(posedge aclk);
		standby_link_ok <= 1'b1;
		remote_io_ring_ok <= 1'b1;
		$display("t_link done");
	endtask
	task automatic t_stop();
		wr(`RCR_ADDR_CTRL, 32'h0);
		wait_role(RCR_STOP, 4);
		edge_set(2);
		rd(`RCR_ADDR_IRQ_ST, 32'h7, `RCR_AXI_OKAY);
		`CHK(irq, 1'b1)
		wr(`RCR_ADDR_IRQ_MSK, 32'h0);
		edge_set(3);
		`CHK(irq, 1'b0)
		wr(`RCR_ADDR_IRQ_ST, 32'h7);
		rd(`RCR_ADDR_IRQ_ST, 32'h0, `RCR_AXI_OKAY);
		$display("t_stop done");
	endtask
	task automatic t_sim();
		@(posedge aclk);
		aresetn <= 1'b0;
		prun <= 1'b0;
		id_sel <= RCR_SEL_B;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		// both controllers reach wait on the same edge
		fork
			wr(`RCR_ADDR_CTRL, 32'h1);
			begin
				repeat (4) @(posedge aclk);
				prun <= 1'b1;
			end
		join
		wait_role(RCR_STANDBY, 10);
		`CHK(peer_role, RCR_PRIMARY)
		$display("t_sim done");
	endtask
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_seq();
		t_swap();
		t_lost();
		t_link();
		t_stop();
		t_sim();
		results();
	end
endmodule
